// ===== hdl/aclk_fifo.sv
// Playback sample FIFO with a registered head word
`timescale 1ns/1ns
module aclk_fifo #(
	parameter int W = 20,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic codec_reset_n_n,
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [W-1:0] wrData,
	output logic rdValid,
	input wire logic rdReady,
	output logic [W-1:0] rdData
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic [W-1:0] head_reg, head_next;
	logic headV_reg, headV_next, doWr, doRd, memWr;

	// Head register is refilled from memory, or straight from the writer when empty
	always_comb begin
		doWr = wrValid && wrReady;
		doRd = rdReady && headV_reg;
		wp_next = wp_reg;
		rp_next = rp_reg;
		cnt_next = cnt_reg;
		head_next = head_reg;
		headV_next = headV_reg;
		memWr = 1'b0;
		if (!headV_reg || doRd) begin
			if (cnt_reg != '0) begin
				head_next = mem[rp_reg];
				headV_next = 1'b1;
				rp_next = rp_reg + 1'b1;
				cnt_next = cnt_reg - 1'b1;
				memWr = doWr;
			end else begin
				head_next = doWr ? wrData : head_reg;
				headV_next = doWr;
			end
		end else begin
			memWr = doWr;
		end
		if (memWr) begin
			wp_next = wp_reg + 1'b1;
			cnt_next = cnt_next + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (memWr) begin
			mem[wp_reg] <= wrData;
		end
	end

	always_ff @(posedge clk or negedge codec_reset_n_n) begin
		if (!codec_reset_n_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
			head_reg <= '0;
			headV_reg <= 1'b0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			cnt_reg <= cnt_next;
			head_reg <= head_next;
			headV_reg <= headV_next;
		end
	end

	// Full stalls the writer, so back-pressure reaches the source
	assign wrReady = cnt_reg < (AW+1)'(DEPTH);
	assign rdValid = headV_reg;
	assign rdData = head_reg;
endmodule // aclk_fifo

// ===== hdl/aclk_link.sv
// Link frame engine: on-demand gating, power-down, loopbacks, control register
`timescale 1ns/1ns
module aclk_link (
	input wire logic clk,
	input wire logic codec_reset_n_n,
	input wire logic ctlWrite,
	input wire logic [11:0] ctlAddr,
	input wire logic [31:0] ctlWdata,
	output logic [31:0] ctlRdata,
	input wire logic [aclk_pkg::OD_SLOTS-1:0] outputSlotValid,
	input wire logic validFrame,
	input wire logic syncGenEnable,
	input wire logic syncForce,
	input wire logic codecResetRelease,
	input wire logic secondaryTargetSelect,
	input wire logic linkBitClock,
	input wire logic primarySerialIn,
	input wire logic secondarySerialIn,
	input wire logic volUpIn,
	input wire logic volDnIn,
	input wire logic volOnSecondary,
	input wire logic playValid,
	output logic playReady,
	input wire logic [aclk_pkg::SAMPLE_W-1:0] playData,
	output aclk_pkg::aclk_link_type linkPins,
	output aclk_pkg::aclk_rec_type [1:0] recOut,
	output logic [aclk_pkg::OD_SLOTS-1:0] primaryOnDemandStatus,
	output logic [aclk_pkg::OD_SLOTS-1:0] secondaryOnDemandStatus,
	output logic primaryCodecReady,
	output logic secondaryCodecReady,
	output logic linkDown,
	output logic volUpOut,
	output logic volDnOut
);
	import aclk_pkg::*;

	logic [31:0] ctl_reg, ctl_next, rd_reg, rd_next;
	logic [4:0] pinS;
	logic bclkD_reg, rise, fall, engineOn, gate, pop, fifoValid;
	logic [7:0] wdog_reg, wdog_next;
	logic [3:0] slot_reg, slot_next, idx;
	logic [4:0] bitLeft_reg, bitLeft_next;
	logic [SAMPLE_W-1:0] txShift_reg, txShift_next, fifoData;
	logic sync_reg, sync_next, sdo_reg, sdo_next, sdoPin_reg, sdoPin_next;
	logic rstOut_reg;
	logic [OD_SLOTS-1:0] txMask_reg, txMask_next, mask;
	logic [15:0] word0;
	logic [1:0][SAMPLE_W-1:0] rxShift_reg, rxShift_next;
	logic [1:0][OD_SLOTS-1:0] inTag_reg, inTag_next, req_reg, req_next;
	logic [1:0][OD_SLOTS-1:0] odStat_reg, odStat_next;
	logic [1:0] ready_reg, ready_next, rxIn, odEn;
	aclk_rec_type [1:0] rec_reg, rec_next;
	logic [1:0] vol_reg, vol_next;

	// Pin levels and bit clock pass two flops first
	aclk_sync2 #(.W(5)) uPinSync (
		.clk(clk),
		.codec_reset_n_n(codec_reset_n_n),
		.d({linkBitClock, primarySerialIn, secondarySerialIn, volUpIn, volDnIn}),
		.q(pinS)
	);

	aclk_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) uPlayFifo (
		.clk(clk),
		.codec_reset_n_n(codec_reset_n_n),
		.wrValid(playValid),
		.wrReady(playReady),
		.wrData(playData),
		.rdValid(fifoValid),
		.rdReady(pop),
		.rdData(fifoData)
	);

	// Control register; read-only fields are rebuilt on every write
	always_comb begin
		ctl_next = ctl_reg;
		if (ctlWrite && ctlAddr == LMC_OFFSET) begin
			ctl_next = (ctlWdata & LMC_WR_MASK) | (LMC_RESET & ~LMC_WR_MASK);
		end
		rd_next = (ctlAddr == LMC_OFFSET) ? ctl_reg : '0;
	end

	always_ff @(posedge clk or negedge codec_reset_n_n) begin
		if (!codec_reset_n_n) begin
			ctl_reg <= LMC_RESET;
			rd_reg <= '0;
		end else begin
			ctl_reg <= ctl_next;
			rd_reg <= rd_next;
		end
	end

	assign odEn = {ctl_reg[B_SEC_OD_EN], ctl_reg[B_PRI_OD_EN]};
	assign rise = pinS[4] && !bclkD_reg;
	assign fall = !pinS[4] && bclkD_reg;
	// Watchdog saturates at the loss count; reset starts it saturated
	assign linkDown = (wdog_reg == BCLK_LOSS_CYC);
	assign engineOn = syncGenEnable && !linkDown;
	assign gate = !ctl_reg[B_READY_GATE] || (|ready_reg);

	// Frame engine: drive on bit clock rise, sample on fall
	always_comb begin
		wdog_next = wdog_reg;
		slot_next = slot_reg;
		bitLeft_next = bitLeft_reg;
		txShift_next = txShift_reg;
		sync_next = sync_reg;
		sdo_next = sdo_reg;
		txMask_next = txMask_reg;
		rxShift_next = rxShift_reg;
		inTag_next = inTag_reg;
		req_next = req_reg;
		odStat_next = odStat_reg;
		ready_next = ready_reg;
		rec_next = rec_reg;
		pop = 1'b0;
		mask = '0;
		word0 = '0;
		idx = '0;
		rec_next[0].valid = 1'b0;
		rec_next[1].valid = 1'b0;
		// Loss of bit clock
		if (rise || fall) begin
			wdog_next = '0;
		end else if (!linkDown) begin
			wdog_next = wdog_reg + 8'h01;
		end
		rxIn[0] = ctl_reg[B_PRI_INT_LOOP] ? sdo_reg : pinS[3];
		rxIn[1] = ctl_reg[B_SEC_INT_LOOP] ? sdo_reg : pinS[2];
		if (!engineOn) begin
			// Held in reset; next bit clock rise after release opens a fresh frame
			slot_next = SLOT_LAST;
			bitLeft_next = '0;
			txShift_next = '0;
			sync_next = 1'b0;
			sdo_next = 1'b0;
			txMask_next = '0;
			if (linkDown) begin
				ready_next = '0;
			end
		end else begin
			if (rise) begin
				if (bitLeft_reg == '0) begin
					if (slot_reg == SLOT_LAST) begin
						// Frame start: fixed 256-bit frame paced only by the bit clock
						slot_next = '0;
						bitLeft_next = SLOT0_LAST_BIT;
						for (int c = 0; c < 2; c++) begin
							odStat_next[c] = odEn[c] ? req_reg[c] : '0;
						end
						if (gate) begin
							mask = outputSlotValid & ~(odStat_next[0] | odStat_next[1]);
						end
						txMask_next = mask;
						word0[S0_VALID_BIT] = validFrame || (|mask) || ctl_reg[B_LOOP_FORCE_FV];
						for (int i = 0; i < OD_SLOTS; i++) begin
							word0[S0_TAG_TOP-i] = mask[i];
						end
						word0[1:0] = secondaryTargetSelect ? ctl_reg[B_TARGET_CODEC_IDENTIFIER_LSB+:2] : 2'b00;
						txShift_next = {word0, 4'h0};
					end else begin
						slot_next = slot_reg + 4'h1;
						bitLeft_next = SLOT_LAST_BIT;
						idx = slot_next - SLOT_FIRST_OD;
						txShift_next = '0;
						// One sample per active slot per frame; slot 12 never carries one
						if (slot_next >= SLOT_FIRST_OD && slot_next <= SLOT_LAST_OD) begin
							if (txMask_reg[idx] && fifoValid) begin
								txShift_next = fifoData;
								pop = 1'b1;
							end
						end
					end
					sdo_next = txShift_next[SAMPLE_W-1];
					sync_next = (slot_next == '0);
				end else begin
					txShift_next = {txShift_reg[SAMPLE_W-2:0], 1'b0};
					sdo_next = txShift_reg[SAMPLE_W-2];
					bitLeft_next = bitLeft_reg - 5'h01;
					sync_next = (slot_reg == '0);
				end
			end
			if (fall) begin
				for (int c = 0; c < 2; c++) begin
					rxShift_next[c] = {rxShift_reg[c][SAMPLE_W-2:0], rxIn[c]};
					if (bitLeft_reg == '0) begin
						if (slot_reg == '0) begin
							ready_next[c] = rxShift_next[c][S0_VALID_BIT];
							for (int i = 0; i < OD_SLOTS; i++) begin
								inTag_next[c][i] = rxShift_next[c][S0_TAG_TOP-i];
							end
						end else if (slot_reg == SLOT_CMD_ADDR) begin
							for (int i = 0; i < OD_SLOTS; i++) begin
								req_next[c][i] = rxShift_next[c][S1_REQ_TOP-i];
							end
						end else if (slot_reg >= SLOT_FIRST_OD && slot_reg <= SLOT_LAST_OD) begin
							idx = slot_reg - SLOT_FIRST_OD;
							if (inTag_reg[c][idx]) begin
								rec_next[c].valid = 1'b1;
								rec_next[c].codec = 1'(c);
								rec_next[c].slot = slot_reg;
								rec_next[c].data = rxShift_next[c];
							end
						end
					end
				end
			end
		end
		for (int c = 0; c < 2; c++) begin
			if (!odEn[c]) begin
				odStat_next[c] = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge codec_reset_n_n) begin
		if (!codec_reset_n_n) begin
			bclkD_reg <= 1'b0;
			wdog_reg <= BCLK_LOSS_CYC;
			slot_reg <= SLOT_LAST;
			bitLeft_reg <= '0;
			txShift_reg <= '0;
			sync_reg <= 1'b0;
			sdo_reg <= 1'b0;
			txMask_reg <= '0;
			rxShift_reg <= '0;
			inTag_reg <= '0;
			req_reg <= '0;
			odStat_reg <= '0;
			ready_reg <= '0;
			rec_reg <= '0;
		end else begin
			bclkD_reg <= pinS[4];
			wdog_reg <= wdog_next;
			slot_reg <= slot_next;
			bitLeft_reg <= bitLeft_next;
			txShift_reg <= txShift_next;
			sync_reg <= sync_next;
			sdo_reg <= sdo_next;
			txMask_reg <= txMask_next;
			rxShift_reg <= rxShift_next;
			inTag_reg <= inTag_next;
			req_reg <= req_next;
			odStat_reg <= odStat_next;
			ready_reg <= ready_next;
			rec_reg <= rec_next;
		end
	end

	// Pin stage: loopback mux, volume freeze, reset pin
	always_comb begin
		sdoPin_next = sdo_reg;
		if (ctl_reg[B_PRI_PIN_LOOP]) begin
			sdoPin_next = pinS[3];
		end else if (ctl_reg[B_SEC_PIN_LOOP]) begin
			sdoPin_next = pinS[2];
		end
		vol_next = vol_reg;
		// Frozen until the codec carrying the volume pins reports ready
		if (!linkDown && (volOnSecondary ? ready_reg[1] : ready_reg[0])) begin
			vol_next = pinS[1:0];
		end
	end

	always_ff @(posedge clk or negedge codec_reset_n_n) begin
		if (!codec_reset_n_n) begin
			sdoPin_reg <= 1'b0;
			vol_reg <= '0;
			rstOut_reg <= 1'b0;
		end else begin
			sdoPin_reg <= sdoPin_next;
			vol_reg <= vol_next;
			rstOut_reg <= codecResetRelease;
		end
	end

	// Sync force bypasses the clock so a warm restart works with the link down
	assign linkPins.syncOut = sync_reg || syncForce;
	assign linkPins.dataOut = sdoPin_reg;
	assign linkPins.resetN = rstOut_reg;
	assign ctlRdata = rd_reg;
	assign recOut = rec_reg;
	assign primaryOnDemandStatus = odStat_reg[0];
	assign secondaryOnDemandStatus = odStat_reg[1];
	assign primaryCodecReady = ready_reg[0];
	assign secondaryCodecReady = ready_reg[1];
	assign volUpOut = vol_reg[1];
	assign volDnOut = vol_reg[0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!codec_reset_n_n);

	logic frameLoad;
	assign frameLoad = engineOn && rise && bitLeft_reg == '0 && slot_reg == SLOT_LAST;

	chk_ro_fields: assert property (ctl_reg[3:0] == LMC_RO_VALUE)
		else $error("read-only control fields changed");
	chk_write_mask: assert property (ctlWrite && ctlAddr == LMC_OFFSET |=>
		(ctl_reg & ~LMC_WR_MASK) == (LMC_RESET & ~LMC_WR_MASK))
		else $error("write reached a read-only field");
	chk_lost_quiet: assert property (linkDown |=> !sync_reg && !sdo_reg)
		else $error("sync or data active with bit clock lost");
	chk_disable_hold: assert property (!syncGenEnable[*2] |-> !sync_reg && !sdo_reg)
		else $error("frame engine active while disabled");
	chk_status_zero: assert property (!odEn[0] |=> odStat_reg[0] == '0)
		else $error("primary on-demand status not cleared");
	chk_hold_block: assert property ((txMask_reg & (odStat_reg[0] | odStat_reg[1])) == '0)
		else $error("held slot still tagged for sending");
	chk_ready_gate: assert property (frameLoad && !gate |=> txMask_reg == '0)
		else $error("data tagged before any codec ready");
	chk_pin_loop: assert property (ctl_reg[B_PRI_PIN_LOOP] ##1 ctl_reg[B_PRI_PIN_LOOP] |->
		sdoPin_reg == $past(pinS[3]))
		else $error("primary pin loop not driving output");
	// Id compared with the values seen at the load edge, so a write there cannot fool it
	chk_codec_id: assert property (frameLoad |=> txShift_reg[5:4] ==
		($past(secondaryTargetSelect) ? $past(ctl_reg[B_TARGET_CODEC_IDENTIFIER_LSB+:2]) : 2'b00))
		else $error("codec id bits wrong in slot 0");
	chk_frame_valid: assert property (frameLoad && ctl_reg[B_LOOP_FORCE_FV] |=>
		txShift_reg[SAMPLE_W-1] && sync_reg)
		else $error("forced frame valid missing");

	cov_frame_start: cover property (frameLoad ##1 sync_reg);
	cov_slot_held: cover property (frameLoad ##1 (odStat_reg[0] & outputSlotValid) != '0);
	cov_link_restart: cover property (linkDown ##1 !linkDown);
	cov_record_push: cover property (rec_reg[1].valid);
endmodule // aclk_link

// ===== hdl/aclk_pkg.sv
// Constants, field positions and carrier types for the link engine
// How it works
// - Frames are fixed 256-bit frames, paced only by the bit clock
// - Only input slots whose slot 0 tag is set leave as record data
// - Each active output slot takes one FIFO sample every frame
// - On-demand holds cover output slots 3 to 11 only, never slot 12
// - Slot 1 request bits latch, move to status at next frame start
// - Held slot sends no data and its slot 0 tag is cleared
// - On-demand enable clear forces that codec's status to zero
// - Bit clock loss resets framing, forcing sync and data low
// - After power up, sending starts once either codec is ready; code sends at once, as the ready gate bit resets to 0
// - Warm restart: sync forced high one microsecond, then low
// - Cold restart: codec reset driven low one microsecond, then high
// - Bit clock return releases sync and data and starts a new frame
// - Volume inputs frozen while link down until attached codec ready
// - Internal loop bits feed serial output back into either input
// - Pin loop bits drive output pin from an input; primary wins
// - Loop force bit is OR-ed into the slot 0 frame valid bit
// - Target codec id goes in slot 0 when secondary target selected
// - Ready gate bit set requires a ready codec before data is sent
// - Master enable reads 1 and timing field reads 001
// - Sync generation enable clear holds the frame engine in reset
package aclk_pkg;
	// Control register
	localparam logic [11:0] LMC_OFFSET = 12'h420;
	localparam logic [31:0] LMC_RESET = 32'h0001_0003;
	localparam logic [31:0] LMC_WR_MASK = 32'h0B3B_0030;
	localparam int B_PRI_INT_LOOP = 4;
	localparam int B_PRI_PIN_LOOP = 5;
	localparam int B_TARGET_CODEC_IDENTIFIER_LSB = 16;
	localparam int B_LOOP_FORCE_FV = 19;
	localparam int B_SEC_INT_LOOP = 20;
	localparam int B_SEC_PIN_LOOP = 21;
	localparam int B_PRI_OD_EN = 24;
	localparam int B_SEC_OD_EN = 25;
	localparam int B_READY_GATE = 27;
	localparam logic [3:0] LMC_RO_VALUE = 4'h3;
	// Frame layout
	localparam int SAMPLE_W = 20;
	localparam int OD_SLOTS = 9;
	localparam logic [4:0] SLOT_LAST_BIT = 5'h13;
	localparam logic [4:0] SLOT0_LAST_BIT = 5'h0f;
	localparam logic [3:0] SLOT_CMD_ADDR = 4'h1;
	localparam logic [3:0] SLOT_FIRST_OD = 4'h3;
	localparam logic [3:0] SLOT_LAST_OD = 4'hb;
	localparam logic [3:0] SLOT_LAST = 4'hc;
	localparam int S0_VALID_BIT = 15;
	localparam int S0_TAG_TOP = 12;
	localparam int S1_REQ_TOP = 11;
	// Timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int BCLK_LOSS_NS = 1600;
	localparam logic [7:0] BCLK_LOSS_CYC =
		8'((BCLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int FIFO_DEPTH = 16;
	// Carriers
	typedef struct packed {
		logic syncOut;
		logic dataOut;
		logic resetN;
	} aclk_link_type;
	typedef struct packed {
		logic valid;
		logic codec;
		logic [3:0] slot;
		logic [SAMPLE_W-1:0] data;
	} aclk_rec_type;
endpackage

// ===== hdl/aclk_sync2.sv
// Two-flop synchroniser for a bundle of outside levels
`timescale 1ns/1ns
module aclk_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic codec_reset_n_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;

	// First stage is read only by the second
	always_comb begin
		meta_next = d;
	end

	always_ff @(posedge clk or negedge codec_reset_n_n) begin
		if (!codec_reset_n_n) begin
			meta_reg <= '0;
			q_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			q_reg <= meta_reg;
		end
	end

	assign q = q_reg;
endmodule // aclk_sync2

// ===== tb/aclk_codec_model.sv
// Behavioural pair of link codecs sharing one bit clock
`timescale 1ns/1ns
module aclk_codec_model (
	input wire logic run,
	input wire logic priReady,
	input wire logic secReady,
	input wire logic request,
	input wire logic syncIn,
	output logic bitClk,
	output logic priSd,
	output logic secSd
);
	int bitIdx = 300;
	logic syncPrev = 1'b0;
	// Ready spans three bits and requests eleven, so one bit of skew still decodes
	function automatic logic [255:0] frame(input logic rdy);
		logic [255:0] f;
		f = '0;
		f[255 -: 3] = {3{rdy}};
		f[232 -: 11] = {11{request}};
		return f;
	endfunction
	// Clock stands low while powered down; odd offset keeps edges off clk
	initial begin
		bitClk = 1'b0;
		priSd = 1'b0;
		secSd = 1'b0;
		forever begin
			wait (run);
			#23;
			while (run) begin
				#400 bitClk = ~bitClk;
			end
			bitClk = 1'b0;
			priSd = 1'b0;
			secSd = 1'b0;
		end
	end
	// Sync seen on a falling edge; the engine samples slot 0 bit 15 on this same fall
	always @(negedge bitClk) begin
		if (syncIn && !syncPrev) begin
			bitIdx = 0;
			priSd <= priReady;
			secSd <= secReady;
		end
		syncPrev = syncIn;
	end
	always @(posedge bitClk) begin
		logic [255:0] p;
		logic [255:0] s;
		p = frame(priReady);
		s = frame(secReady);
		bitIdx = (bitIdx < 256) ? bitIdx + 1 : bitIdx;
		priSd <= (bitIdx < 256) ? p[255 - bitIdx] : 1'b0;
		secSd <= (bitIdx < 256) ? s[255 - bitIdx] : 1'b0;
	end
endmodule // aclk_codec_model

// ===== tb/aclk_link_tb_top.sv
// Self-checking bench for the link engine with two modelled codecs
`timescale 1ns/1ns
module aclk_link_tb_top;
	import aclk_pkg::*;
	logic clk = 1'b0, codec_reset_n_n = 1'b0, ctlWrite = 1'b0;
	logic [11:0] ctlAddr = LMC_OFFSET;
	logic [31:0] ctlWdata = '0, ctlRdata;
	logic [OD_SLOTS-1:0] outputSlotValid = '0, primaryOnDemandStatus, secondaryOnDemandStatus;
	logic validFrame = 1'b0, syncGenEnable = 1'b0, syncForce = 1'b0, codecResetRelease = 1'b0;
	logic secondaryTargetSelect = 1'b0, volUpIn = 1'b0, volOnSecondary = 1'b0, playValid = 1'b0;
	logic [SAMPLE_W-1:0] playData = '0;
	logic linkBitClock, primarySerialIn, secondarySerialIn, playReady;
	logic primaryCodecReady, secondaryCodecReady, linkDown, volUpOut, volDnOut;
	logic volDnIn = 1'b0;
	aclk_link_type linkPins;
	aclk_rec_type [1:0] recOut;
	int nRec = 0;
	logic [3:0] recSlot = '0;
	logic run = 1'b0, priRdy = 1'b1, secRdy = 1'b1, req = 1'b0;
	logic ovr = 1'b0, ovrPri = 1'b0, ovrSec = 1'b0, modelPri, modelSec;
	int nMismatch = 0, samplesChecked = 0, cycles = 0;

	always #50 clk = ~clk;
	// Bench can take the serial inputs over for pin loop checks
	assign primarySerialIn = ovr ? ovrPri : modelPri;
	assign secondarySerialIn = ovr ? ovrSec : modelSec;

	aclk_link dut (.clk, .codec_reset_n_n, .ctlWrite, .ctlAddr, .ctlWdata, .ctlRdata, .outputSlotValid,
		.validFrame, .syncGenEnable, .syncForce, .codecResetRelease, .secondaryTargetSelect,
		.linkBitClock, .primarySerialIn, .secondarySerialIn, .volUpIn, .volDnIn,
		.volOnSecondary, .playValid, .playReady, .playData, .linkPins, .recOut,
		.primaryOnDemandStatus, .secondaryOnDemandStatus, .primaryCodecReady,
		.secondaryCodecReady, .linkDown, .volUpOut, .volDnOut);
	aclk_codec_model codecs (.run(run), .priReady(priRdy), .secReady(secRdy), .request(req),
		.syncIn(linkPins.syncOut), .bitClk(linkBitClock), .priSd(modelPri), .secSd(modelSec));

	// Primary records counted off the edge, once the registered pulse has settled
	always @(negedge clk) begin
		if (recOut[0].valid === 1'b1) begin
			nRec++;
			recSlot = recOut[0].slot;
		end
	end
	task automatic go(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samplesChecked++;
		if (got !== exp) begin
			nMismatch++;
			$display("unexpected at %0t ns: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		ctlWrite <= 1'b1;
		ctlAddr <= a;
		ctlWdata <= d;
		@(posedge clk);
		ctlWrite <= 1'b0;
		ctlAddr <= LMC_OFFSET;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v);
		@(posedge clk);
		ctlAddr <= a;
		go(2);
		@(negedge clk);
		v = ctlRdata;
	endtask
	// Bounded wait for the next rise of sync
	task automatic waitRise();
		int n;
		n = 0;
		@(negedge clk);
		while (linkPins.syncOut !== 1'b0 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		while (linkPins.syncOut !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		chk(n < 5000, 1'b1, "frame start");
	endtask
	// Bit k is still on the pin at bit clock rise k+1
	task automatic cap0(output logic [15:0] v);
		waitRise();
		v = '0;
		repeat (16) begin
			@(posedge linkBitClock);
			v = {v[14:0], linkPins.dataOut};
		end
	endtask
	function automatic logic [15:0] slot0(input logic fv, input logic [8:0] t, input logic [1:0] id);
		logic [8:0] r;
		for (int i = 0; i < 9; i++) r[8 - i] = t[i];
		return {fv, 2'b00, r, 2'b00, id};
	endfunction

	task automatic t_register();
		logic [31:0] v;
		rd(LMC_OFFSET, v);
		chk(v, LMC_RESET, "reset value");
		wr(LMC_OFFSET, 32'hffff_ffff);
		rd(LMC_OFFSET, v);
		chk(v, 32'h0b3b_0033, "masked write");
		wr(12'h424, 32'h0000_0000);
		rd(12'h424, v);
		chk(v, 32'h0000_0000, "unmapped read");
		rd(LMC_OFFSET, v);
		chk(v, 32'h0b3b_0033, "unmapped write");
		wr(LMC_OFFSET, 32'h0000_0000);
		rd(LMC_OFFSET, v);
		chk(v, 32'h0000_0003, "fixed bits");
	endtask
	// Engine held, so the buffer fills until it refuses
	task automatic t_fifo_fill();
		int taken;
		taken = 0;
		repeat (20) begin
			@(posedge clk);
			playValid <= 1'b1;
			playData <= playData + 20'h0_0001;
			@(negedge clk);
			if (playReady === 1'b1) taken++;
		end
		@(posedge clk);
		playValid <= 1'b0;
		chk(taken, FIFO_DEPTH + 1, "fifo accepted");
	endtask
	task automatic t_framing();
		int hi, lo;
		go(300);
		chk({linkPins.syncOut, linkPins.dataOut}, 2'b00, "held engine");
		syncGenEnable <= 1'b1;
		outputSlotValid <= 9'h1ff;
		validFrame <= 1'b1;
		waitRise();
		hi = 0;
		lo = 0;
		while (linkPins.syncOut === 1'b1 && hi < 5000) begin
			@(negedge clk);
			hi++;
		end
		while (linkPins.syncOut === 1'b0 && lo < 5000) begin
			@(negedge clk);
			lo++;
		end
		chk(hi, 128, "sync width");
		chk(hi + lo, 2048, "frame length");
	endtask
	task automatic t_on_demand();
		logic [15:0] s;
		req <= 1'b1;
		wr(LMC_OFFSET, 32'h0100_0000);
		cap0(s);
		cap0(s);
		cap0(s);
		chk(primaryOnDemandStatus, 9'h1ff, "primary holds");
		chk(secondaryOnDemandStatus, 9'h000, "secondary off");
		chk(s, slot0(1'b1, 9'h000, 2'b00), "held tags");
		wr(LMC_OFFSET, 32'h0200_0000);
		go(3);
		chk(primaryOnDemandStatus, 9'h000, "primary cleared");
		cap0(s);
		cap0(s);
		cap0(s);
		chk(secondaryOnDemandStatus, 9'h1ff, "secondary holds");
		chk(s, slot0(1'b1, 9'h000, 2'b00), "either holds");
		@(posedge clk);
		req <= 1'b0;
		wr(LMC_OFFSET, 32'h0000_0000);
		cap0(s);
		cap0(s);
		chk(s, slot0(1'b1, 9'h1ff, 2'b00), "all slots sent");
		chk(playReady, 1'b1, "fifo drained");
	endtask
	task automatic t_target_id();
		logic [15:0] s;
		@(posedge clk);
		validFrame <= 1'b0;
		outputSlotValid <= 9'h000;
		secondaryTargetSelect <= 1'b1;
		wr(LMC_OFFSET, 32'h000a_0000);
		cap0(s);
		cap0(s);
		chk(s, slot0(1'b1, 9'h000, 2'b10), "id and forced valid");
		wr(LMC_OFFSET, 32'h0002_0000);
		secondaryTargetSelect <= 1'b0;
		cap0(s);
		cap0(s);
		chk(s, slot0(1'b0, 9'h000, 2'b00), "no id, no valid");
	endtask
	task automatic t_ready_gate();
		logic [15:0] s;
		@(posedge clk);
		priRdy <= 1'b0;
		secRdy <= 1'b0;
		validFrame <= 1'b1;
		outputSlotValid <= 9'h001;
		cap0(s);
		cap0(s);
		chk(primaryCodecReady, 1'b0, "primary not ready");
		chk(s, slot0(1'b1, 9'h001, 2'b00), "ungated");
		wr(LMC_OFFSET, 32'h0800_0000);
		cap0(s);
		cap0(s);
		chk(s, slot0(1'b1, 9'h000, 2'b00), "gated");
		secRdy <= 1'b1;
		cap0(s);
		cap0(s);
		chk(secondaryCodecReady, 1'b1, "secondary ready");
		chk(s, slot0(1'b1, 9'h001, 2'b00), "either ready");
	endtask
	// Codecs silent, so readiness can only come from the looped output
	task automatic t_internal_loop();
		logic [15:0] s;
		@(posedge clk);
		secRdy <= 1'b0;
		wr(LMC_OFFSET, 32'h0000_0010);
		cap0(s);
		cap0(s);
		chk({primaryCodecReady, secondaryCodecReady}, 2'b10, "primary loop");
		nRec = 0;
		cap0(s);
		chk(nRec, 1, "one tagged record");
		chk(recSlot, SLOT_FIRST_OD, "record slot");
		wr(LMC_OFFSET, 32'h0010_0000);
		cap0(s);
		cap0(s);
		chk({primaryCodecReady, secondaryCodecReady}, 2'b01, "secondary loop");
	endtask
	task automatic t_pin_loop();
		logic [3:0] c [4] = '{4'he, 4'hd, 4'h5, 4'h6};
		logic [3:0] e = 4'ha;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			ovr <= 1'b1;
			ovrPri <= c[i][1];
			ovrSec <= c[i][0];
			wr(LMC_OFFSET, {10'h000, c[i][2], 15'h0000, c[i][3], 5'h00});
			go(6);
			@(negedge clk);
			chk(linkPins.dataOut, e[3 - i], "pin loop");
		end
		wr(LMC_OFFSET, 32'h0000_0000);
		ovr <= 1'b0;
	endtask
	task automatic t_power_cycle();
		logic [15:0] s;
		@(posedge clk);
		secRdy <= 1'b1;
		volOnSecondary <= 1'b1;
		volUpIn <= 1'b1;
		cap0(s);
		cap0(s);
		chk(volUpOut, 1'b1, "volume follows");
		@(posedge clk);
		outputSlotValid <= 9'h000;
		run <= 1'b0;
		secRdy <= 1'b0;
		go(40);
		volUpIn <= 1'b0;
		volDnIn <= 1'b1;
		go(10);
		@(negedge clk);
		chk({linkDown, linkPins.syncOut, linkPins.dataOut}, 3'h4, "link lost");
		chk({volUpOut, volDnOut}, 2'b10, "volume frozen");
		go(4 * 2048);
		syncForce <= 1'b1;
		go(5);
		@(negedge clk);
		chk(linkPins.syncOut, 1'b1, "warm pulse");
		go(5);
		syncForce <= 1'b0;
		run <= 1'b1;
		cap0(s);
		chk(linkDown, 1'b0, "clock back");
		chk({volUpOut, volDnOut}, 2'b10, "frozen until ready");
		secRdy <= 1'b1;
		cap0(s);
		cap0(s);
		chk({volUpOut, volDnOut}, 2'b01, "volume released");
		@(posedge clk);
		codecResetRelease <= 1'b0;
		go(2);
		@(negedge clk);
		chk(linkPins.resetN, 1'b0, "cold reset");
		go(8);
		codecResetRelease <= 1'b1;
		go(2);
		@(negedge clk);
		chk(linkPins.resetN, 1'b1, "reset released");
	endtask

	task automatic tally_and_finish();
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Hang guard, well above the planned run length
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 95000) begin
			nMismatch++;
			$display("unexpected at %0t ns: run timed out", $time);
			tally_and_finish();
		end
	end
	initial begin
		go(8);
		codec_reset_n_n <= 1'b1;
		go(1);
		codecResetRelease <= 1'b1;
		run <= 1'b1;
		t_register();
		t_fifo_fill();
		t_framing();
		t_on_demand();
		t_target_id();
		t_ready_gate();
		t_internal_loop();
		t_pin_loop();
		t_power_cycle();
		tally_and_finish();
	end
endmodule // aclk_link_tb_top
